// ### test/host_uart_sink.sv
// byte sink standing in for the host serial port
`timescale 1ns/100ps
`default_nettype none
module host_uart_sink (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // byte stream from the framer
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var  logic       tx_ready,
    // bench side
    input  wire logic       stall,
    output var  logic [7:0] rx_byte,
    output var  logic       rx_stb
);
    // ----
    // accept a byte when stall was low the cycle before; a stall may land mid-sentence
    // ----
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            rx_stb   <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            tx_ready <= !stall;
            rx_stb   <= tx_valid && tx_ready;
            if (tx_valid && tx_ready)
                rx_byte <= tx_data;
        end
    end
endmodule // host_uart_sink
`default_nettype wire

// ### test/sentence_tx_props.sv
// assertions on the sentence framer ports
`timescale 1ns/100ps
`default_nettype none
module sentence_tx_props (
    // apb
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    // stream and interrupt
    input wire [7:0]  tx_data,
    input wire        tx_valid,
    input wire        tx_ready,
    input wire        irq
);
    // ----
    // helpers
    // ----
    reg  [4:0] pos_r;
    reg  [7:0] prev_r;
    reg  [3:0] mask_r;
    reg  [3:0] mask_d_r;
    wire       acc = tx_valid && tx_ready;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_r    <= 5'h00;
            prev_r   <= 8'h00;
            mask_r   <= 4'h0;
            mask_d_r <= 4'h0;
        end else begin
            if (acc) begin
                pos_r  <= (tx_data == 8'h0A) ? 5'h00 : pos_r + 5'h01;
                prev_r <= tx_data;
            end
            if (psel && penable && pready && pwrite && paddr == 12'h020)
                mask_r <= pwdata[3:0];
            // irq is registered, so it may lag a mask write by one cycle
            mask_d_r <= mask_r;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // properties
    // ----
    apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    slverr_map_a: assert property (pready |-> pslverr == (paddr > 12'h024 || paddr[1:0] != 2'b00))
        else $error("wrong slave error");
    irq_mask_a: assert property (irq |-> (mask_r | mask_d_r) != 4'h0) else $error("irq masked");
    start_char_a: assert property (acc && pos_r == 5'h00 |-> tx_data == 8'h24)
        else $error("bad first char");
    class_char_a: assert property (acc && pos_r == 5'h05 |-> tx_data == 8'h56)
        else $error("bad class char");
    line_end_a: assert property (acc && prev_r == 8'h0D |-> tx_data == 8'h0A)
        else $error("no line feed");
    sum_hex_a: assert property (acc && prev_r == 8'h2A |->
        tx_data inside {[8'h30:8'h39], [8'h41:8'h46]}) else $error("bad checksum digit");
    frame_gap_a: assert property (acc && tx_data == 8'h0A |=> !tx_valid)
        else $error("no gap");
    byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte dropped");
endmodule // sentence_tx_props
bind status_sentence_tx sentence_tx_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .irq(irq));
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the status sentence framer
`timescale 1ns/100ps
`default_nettype none
`include "sentence_tx_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    reg         pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, stall = 1'b0, er;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd, seed = 32'hB2A1, st = 32'hB2A1;
    reg  [31:0] course_s, radial_s, ctrl_s, navstat_s = 0, comstat_s, misc_s = 0;
    wire [31:0] prdata;
    wire [7:0]  tx_data, b_dat;
    wire        pready, pslverr, tx_valid, tx_ready, irq, b_stb;
    reg  [7:0]  s [0:31];
    reg  [7:0]  ex [0:7];
    int         n = 0, en, cnt [0:99], n_fail = 0, comparisons = 0, cyc = 0;
    int         i, k, c1, c2, m, ids [0:3] = '{28, 30, 36, 27};
    bit         fchk = 0, arm = 0;
    localparam [31:0] VER = 32'h3031_3130;
    status_sentence_tx #(.PERIOD_CYCLES(200)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .irq(irq));
    host_uart_sink host (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall), .rx_byte(b_dat),
        .rx_stb(b_stb));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // ----
    // helpers
    // ----
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function [7:0] hx(input [3:0] v);
        hx = (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
    endfunction
    task dig(input int v);
        ex[1] = 8'h30 + v / 100;
        ex[2] = 8'h30 + (v / 10) % 10;
        ex[3] = 8'h30 + v % 10;
    endtask
    task exp_fields(input int id);
        en = 0;
        for (int j = 0; j < 4; j++) ex[j] = VER[31 - 8 * j -: 8];
        case (id)
            22: begin dig(course_s[8:0]); ex[0] = course_s[9] ? "V" : "0"; en = 4; end
            23: begin
                dig(radial_s[8:0]);
                ex[0] = (radial_s[13] && !ctrl_s[1]) ? "V" : "0";
                ex[4] = 8'h30 + radial_s[12:9];
                en = 5;
            end
            27: begin ex[0] = 8'h30 + misc_s[13:12]; en = 1; end
            28: begin
                ex[0] = navstat_s[7:0] - 8'h30;
                ex[1] = navstat_s[15:8] + 8'h30;
                ex[2] = navstat_s[16] ? "M" : "N";
                en = 3;
            end
            30: begin ex[4] = misc_s[11] ? "E" : "R"; en = 5; end
            35: begin
                ex[0] = comstat_s[7:0] - 8'h30;
                ex[1] = comstat_s[15:8] + 8'h30;
                ex[2] = comstat_s[23:16] - 8'h30;
                ex[3] = comstat_s[31:24] + 8'h30;
                ex[4] = "RTSF" >> (8 * (3 - misc_s[9:8]));
                ex[5] = misc_s[10] ? "1" : "0";
                en = 6;
            end
            36: en = 4;
            default: en = 0;
        endcase
    endtask
    task check_sent;
        int     id;
        reg [7:0] x;
        id = (s[6] - 48) * 10 + s[7] - 48;
        exp_fields(id);
        x = 8'h00;
        for (int j = 1; j < n - 5; j++) x ^= s[j];
        `CHK(s[0], 8'h24)
        `CHK({s[1], s[2], s[3], s[4], s[5]}, 40'h5858_5858_56)
        `CHK(n, en + 13)
        `CHK({s[n - 4], s[n - 3]}, {hx(x[7:4]), hx(x[3:0])})
        `CHK(s[n - 2], 8'h0D)
        if (fchk || !(id == 22 || id == 23))
            for (int j = 0; j < en; j++) `CHK(s[8 + j], ex[j])
        if (id >= 0 && id < 100) cnt[id]++;
    endtask
    task apb(input bit w, input [11:0] a, input [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 50) begin @(posedge pclk); t++; end
        if (t >= 50) n_fail++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_id(input int id, input int c);
        k = 0;
        while (cnt[id] <= c && k < 3000) begin @(posedge pclk); k++; end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----
    // capture, stalls and timeout
    // ----
    always @(posedge pclk) begin
        st <= lfsr(st);
        stall <= st[3] & st[7];
        cyc++;
        if (cyc == 60000) begin n_fail++; final_report; end
        if (b_stb) begin
            s[n] = b_dat;
            n = (n < 31) ? n + 1 : n;
            if (b_dat == 8'h0A) begin
                check_sent;
                n = 0;
                if (arm) begin fchk = 1; arm = 0; end
            end
        end
    end
    // ----
    // scenarios
    // ----
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        for (i = 0; i < 100; i++) cnt[i] = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `REG_CTRL, 0);
        `CHK(rd, `CTRL_RST)
        apb(0, `REG_IRQ_MASK, 0);
        `CHK(rd[3:0], `MASK_RST)
        apb(0, 12'hFFC, 0);
        `CHK({er, rd}, 33'h1_0000_0000)
        apb(1, `REG_IRQ_MASK, 32'hF);
        apb(1, `REG_VERSION, VER);
        apb(1, `REG_NAVVER, VER);
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            m = (i == 0) ? 0 : (i == 1) ? 359 : seed % 360;
            course_s = (seed[4] << 9) | m;
            radial_s = ((seed[5] | i == 2) << 13) | ((seed[11:8] % 10) << 9) | (359 - m);
            ctrl_s = (seed[6] | i == 2) << 1;
            fchk = 0;
            apb(1, `REG_CTRL, ctrl_s);
            apb(1, `REG_COURSE, course_s);
            apb(1, `REG_RADIAL, radial_s);
            arm = 1;
            c1 = cnt[22];
            c2 = cnt[23];
            k = 0;
            while ((cnt[22] < c1 + 2 || cnt[23] < c2 + 2) && k < 2000) begin
                @(posedge pclk);
                k++;
            end
            `CHK(k < 2000, 1'b1)
        end
        c1 = cnt[22];
        repeat (2000) @(posedge pclk);
        `CHK(cnt[22] - c1 >= 9 && cnt[22] - c1 <= 11, 1'b1)
        $display("test periodic done");
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            navstat_s = (seed[0] << 16) | ((2 * (seed[7:1] % 20)) << 8) | (108 + 3 * i);
            c1 = cnt[28];
            apb(1, `REG_NAVSTAT, navstat_s);
            wait_id(28, c1);
            `CHK(cnt[28] > c1, 1'b1)
        end
        apb(0, `REG_IRQ_STAT, 0);
        `CHK(rd[2], 1'b1)
        c1 = cnt[28];
        apb(1, `REG_NAVSTAT, navstat_s);
        repeat (600) @(posedge pclk);
        `CHK(cnt[28], c1)
        $display("test nav status done");
        for (i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            misc_s = (seed & 32'h0F00) | ((i % 3) << 12);
            c1 = cnt[ids[i % 4]];
            apb(1, `REG_REQ, misc_s | (1 << (i % 4)));
            wait_id(ids[i % 4], c1);
            `CHK(cnt[ids[i % 4]] > c1, 1'b1)
        end
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            misc_s = (i << 8) | (seed[1] << 10);
            apb(1, `REG_REQ, misc_s);
            m = (i == 3) ? 162 : 118 + seed[12:8] % 19;
            comstat_s = ((seed[27:22] % 40) << 24) | ((118 + seed[20:16] % 19) << 16);
            comstat_s = comstat_s | ((seed[5:0] % 40) << 8) | m;
            c1 = cnt[35];
            apb(1, `REG_COMSTAT, comstat_s);
            wait_id(35, c1);
            `CHK(cnt[35] > c1, 1'b1)
        end
        $display("test requests done");
        apb(1, `REG_IRQ_MASK, 0);
        repeat (300) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1, `REG_IRQ_MASK, 32'h4);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        navstat_s = navstat_s ^ 32'h1_0000;
        apb(1, `REG_NAVSTAT, navstat_s);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(0, `REG_IRQ_STAT, 0);
        `CHK(rd[3:2], 2'b11)
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        $display("test interrupt done");
        apb(1, `REG_CTRL, ctrl_s | 1);
        repeat (150) @(posedge pclk);
        c1 = cnt[22];
        repeat (600) @(posedge pclk);
        `CHK(cnt[22], c1)
        $display("test periodic off done");
        final_report;
    end
endmodule // tb_top
`default_nettype wire

// ### verilog/sentence_tx_defines.vh
// constants for the serial status sentence framer
`ifndef SENTENCE_TX_DEFINES_VH
`define SENTENCE_TX_DEFINES_VH

// register byte offsets
`define REG_CTRL      12'h000
`define REG_COURSE    12'h004
`define REG_RADIAL    12'h008
`define REG_NAVSTAT   12'h00C
`define REG_COMSTAT   12'h010
`define REG_VERSION   12'h014
`define REG_REQ       12'h018
`define REG_IRQ_STAT  12'h01C
`define REG_IRQ_MASK  12'h020
`define REG_NAVVER    12'h024

// request register bit positions (write one to request)
`define REQ_NAVSTAT   0
`define REQ_NAVVER    1
`define REQ_COMVER    2
`define REQ_ERR       3

// message identifiers, two ascii digits each
`define ID_COURSE     16'h3232
`define ID_RADIAL     16'h3233
`define ID_ERR        16'h3237
`define ID_NAVSTAT    16'h3238
`define ID_NAVVER     16'h3330
`define ID_COMSTAT    16'h3335
`define ID_COMVER     16'h3336

// periodic timing: 10 Hz at 40 MHz
`define CLK_HZ        40000000
`define PERIOD_HZ     10
`define PERIOD_CYC    (`CLK_HZ / `PERIOD_HZ)

// reset values
`define CTRL_RST      32'h0000_0000
`define MASK_RST      4'h0

`endif

// ### verilog/status_sentence_tx.v
// framer that emits ascii status sentences onto a byte stream
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sentence_tx_defines.vh"

// Function
// R1 - course message 22: validity char '0'/'V' then three degree digits 000-359
// R2 - course and radial messages repeat at 10 Hz from power-up unasked
// R3 - radial message 23: validity char, three degree digits, one tenths digit
// R4 - while tracking a localizer the radial still goes out, marked invalid
// R5 - fault sends message 27 with code '0' checksum, '1' unknown, '2' bad data
// R6 - nav status 28 sent on host request and on every status change
// R7 - nav standby MHz minus 30h, kHz/25 plus 30h, then mode N or M
// R8 - nav version 30: four version characters then release flag R or E
// R9 - com status carries active then standby, MHz-30h and kHz/25+30h each
// R10 - com status 35 ends with status letter R/T/S/F and squelch '0'/'1'
// R11 - com version 36 carries four ascii version characters
// R12 - sentence: '$', fixed prefix, 'V', two-digit id, fields, checksum, CR LF
// R13 - checksum is xor of chars after '$', two uppercase hex digits
// R14 - one whole sentence at a time, never interleaved
module status_sentence_tx #(
    parameter [31:0] PERIOD_CYCLES = `PERIOD_CYC,
    // prefix letters after '$'; arbitrary neutral value
    parameter [31:0] PREFIX        = 32'h5858_5858
) (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // byte stream to the uart
    output reg  [7:0]  tx_data,
    output reg         tx_valid,
    input  wire        tx_ready,
    // interrupt
    output reg         irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [7:0] hex_char;
        input [3:0] n;
        begin
            hex_char = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
        end
    endfunction
    function [23:0] deg3;
        input [8:0] d;
        reg [8:0] h;
        reg [8:0] t;
        reg [8:0] u;
        begin
            h = d / 9'd100;
            t = (d % 9'd100) / 9'd10;
            u = d % 9'd10;
            deg3 = {4'h3, h[3:0], 4'h3, t[3:0], 4'h3, u[3:0]};
        end
    endfunction
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    localparam [2:0] M_COURSE = 3'd0, M_RADIAL = 3'd1, M_ERR = 3'd2, M_NAVSTAT = 3'd3,
                     M_NAVVER = 3'd4, M_COMSTAT = 3'd5, M_COMVER = 3'd6;
    reg [31:0] ctrl_r;      // [0] periodic off, [1] localizer tracking
    reg [31:0] course_r;    // [8:0] degrees, [9] valid
    reg [31:0] radial_r;    // [8:0] degrees, [12:9] tenths, [13] valid
    reg [31:0] navstat_r;   // [7:0] MHz, [15:8] kHz/25, [16] monitor
    reg [31:0] comstat_r;   // [7:0] act MHz,[15:8] act step,[23:16] sb MHz,[31:24] sb step
    reg [31:0] version_r;   // com version, four chars
    reg [31:0] navver_r;    // [31:0] four chars
    reg [7:0]  misc_r;      // [1:0] com status R/T/S/F, [2] squelch test, [3] nav eng, [5:4] err
    reg [3:0]  pend_r;      // navstat, navver, comver, err
    reg        comstat_pend_r;
    reg [3:0]  irq_stat_r;  // sentence done, err sent, navstat change, period tick
    reg [3:0]  irq_mask_r;
    reg [31:0] tick_cnt_r;
    reg        per_pend_r;  // periodic course sentence owed
    wire       wr_en = psel & penable & pwrite & pready;
    wire       rd_en = psel & penable & ~pwrite & pready;
    // read data loads at setup so that it stands when pready is sampled
    wire       rd_setup = psel & ~penable & ~pwrite;
    wire       known = (paddr <= `REG_NAVVER) && (paddr[1:0] == 2'b00);
    // transmitter state (one-hot)
    localparam [2:0] S_IDLE = 3'b001, S_SEND = 3'b010, S_TAIL = 3'b100;
    reg [2:0]  state_r;
    reg [2:0]  msg_r;
    reg [4:0]  idx_r;
    reg [7:0]  sum_r;
    reg [1:0]  tail_r;
    reg        sent_pulse;
    // body characters after '$', up to 16 of them
    reg [7:0]  body [0:15];
    reg [4:0]  body_len;
    integer    i;
    always @* begin
        for (i = 0; i < 16; i = i + 1)
            body[i] = 8'h30;
        body[0] = PREFIX[31:24];
        body[1] = PREFIX[23:16];
        body[2] = PREFIX[15:8];
        body[3] = PREFIX[7:0];
        body[4] = 8'h56;                                      // R12
        body_len = 5'd9;
        case (msg_r)
            M_COURSE: begin
                {body[5], body[6]} = `ID_COURSE;
                body[7] = course_r[9] ? 8'h56 : 8'h30;        // R1
                {body[8], body[9], body[10]} = deg3(course_r[8:0]);
                body_len = 5'd11;
            end
            M_RADIAL: begin
                {body[5], body[6]} = `ID_RADIAL;
                body[7] = (radial_r[13] & ~ctrl_r[1]) ? 8'h56 : 8'h30; // R4
                {body[8], body[9], body[10]} = deg3(radial_r[8:0]); // R3
                body[11] = {4'h3, radial_r[12:9]};
                body_len = 5'd12;
            end
            M_ERR: begin
                {body[5], body[6]} = `ID_ERR;
                body[7] = {6'b001100, misc_r[5:4]};           // R5
                body_len = 5'd8;
            end
            M_NAVSTAT: begin
                {body[5], body[6]} = `ID_NAVSTAT;
                body[7] = navstat_r[7:0] - 8'h30;             // R7
                body[8] = navstat_r[15:8] + 8'h30;
                body[9] = navstat_r[16] ? 8'h4D : 8'h4E;
                body_len = 5'd10;
            end
            M_NAVVER: begin
                {body[5], body[6]} = `ID_NAVVER;
                {body[7], body[8], body[9], body[10]} = navver_r; // R8
                body[11] = misc_r[3] ? 8'h45 : 8'h52;
                body_len = 5'd12;
            end
            M_COMSTAT: begin
                {body[5], body[6]} = `ID_COMSTAT;
                body[7] = comstat_r[7:0] - 8'h30;             // R9
                body[8] = comstat_r[15:8] + 8'h30;
                body[9] = comstat_r[23:16] - 8'h30;
                body[10] = comstat_r[31:24] + 8'h30;
                case (misc_r[1:0])                            // R10
                    2'd0: body[11] = 8'h52;
                    2'd1: body[11] = 8'h54;
                    2'd2: body[11] = 8'h53;
                    default: body[11] = 8'h46;
                endcase
                body[12] = misc_r[2] ? 8'h31 : 8'h30;
                body_len = 5'd13;
            end
            default: begin
                {body[5], body[6]} = `ID_COMVER;
                {body[7], body[8], body[9], body[10]} = version_r; // R11
                body_len = 5'd11;
            end
        endcase
    end

    // ------------------------------------------------------------
    // apb slave, status and request registers
    // ------------------------------------------------------------
    wire navstat_chg = wr_en && (paddr == `REG_NAVSTAT) && (pwdata != navstat_r); // R6
    wire comstat_chg = wr_en && (paddr == `REG_COMSTAT);
    wire tick        = (tick_cnt_r == PERIOD_CYCLES - 32'd1);
    wire start       = (state_r == S_IDLE) && !tx_valid;
    reg  [2:0] pick;
    reg        pick_ok;
    reg        radial_owed_r;
    always @* begin
        pick_ok = 1'b1;                                       // R14
        pick = M_COURSE;
        if (radial_owed_r)       pick = M_RADIAL;
        else if (per_pend_r)     pick = M_COURSE;
        else if (pend_r[3])      pick = M_ERR;
        else if (pend_r[0])      pick = M_NAVSTAT;
        else if (comstat_pend_r) pick = M_COMSTAT;
        else if (pend_r[1])      pick = M_NAVVER;
        else if (pend_r[2])      pick = M_COMVER;
        else                     pick_ok = 1'b0;
    end
    wire launch = start && pick_ok;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RST;
            course_r <= 32'h0;
            radial_r <= 32'h0;
            navstat_r <= 32'h0;
            comstat_r <= 32'h0;
            version_r <= 32'h3030_3030;
            navver_r <= 32'h3030_3030;
            misc_r <= 8'h00;
            pend_r <= 4'h0;
            comstat_pend_r <= 1'b0;
            irq_mask_r <= `MASK_RST;
            irq_stat_r <= 4'h0;
            tick_cnt_r <= 32'h0;
            per_pend_r <= 1'b0;
            radial_owed_r <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'd1;
            // course clears its flag at launch, so a tick during the pair is not lost
            if (launch && radial_owed_r)
                radial_owed_r <= 1'b0;
            else if (launch && per_pend_r) begin
                radial_owed_r <= 1'b1;
                per_pend_r <= 1'b0;
            end
            if (tick && ctrl_r[0] == 1'b0)                    // R2
                per_pend_r <= 1'b1;
            if (wr_en) begin
                case (paddr)
                    `REG_CTRL:     ctrl_r <= pwdata;
                    `REG_COURSE:   course_r <= pwdata;
                    `REG_RADIAL:   radial_r <= pwdata;
                    `REG_NAVSTAT:  navstat_r <= pwdata;
                    `REG_COMSTAT:  comstat_r <= pwdata;
                    `REG_VERSION:  version_r <= pwdata;
                    `REG_NAVVER:   navver_r <= pwdata;
                    `REG_IRQ_MASK: irq_mask_r <= pwdata[3:0];
                    `REG_REQ: begin
                        misc_r <= pwdata[15:8];
                        pend_r <= pend_r | pwdata[3:0];
                    end
                    default: ;
                endcase
            end
            if (launch && !per_pend_r && !radial_owed_r) begin
                case (pick)
                    M_ERR:     pend_r[3] <= 1'b0;
                    M_NAVSTAT: pend_r[0] <= 1'b0;
                    M_COMSTAT: comstat_pend_r <= 1'b0;
                    M_NAVVER:  pend_r[1] <= 1'b0;
                    default:   pend_r[2] <= 1'b0;
                endcase
            end
            if (navstat_chg)                                  // R6
                pend_r[0] <= 1'b1;
            if (comstat_chg)
                comstat_pend_r <= 1'b1;
            if (rd_setup) begin
                case (paddr)
                    `REG_CTRL:     prdata <= ctrl_r;
                    `REG_COURSE:   prdata <= course_r;
                    `REG_RADIAL:   prdata <= radial_r;
                    `REG_NAVSTAT:  prdata <= navstat_r;
                    `REG_COMSTAT:  prdata <= comstat_r;
                    `REG_VERSION:  prdata <= version_r;
                    `REG_NAVVER:   prdata <= navver_r;
                    `REG_REQ:      prdata <= {16'h0, misc_r, 3'b000, state_r != S_IDLE, pend_r};
                    `REG_IRQ_STAT: prdata <= {28'h0, irq_stat_r};
                    `REG_IRQ_MASK: prdata <= {28'h0, irq_mask_r};
                    default:       prdata <= 32'h0;
                endcase
            end
            // read clears only the bits it reported; a new event in the same cycle wins
            irq_stat_r <= ((rd_en && paddr == `REG_IRQ_STAT) ?
                           (irq_stat_r & ~prdata[3:0]) : irq_stat_r)
                          | {tick, navstat_chg, sent_pulse && msg_r == M_ERR, sent_pulse};
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // sentence serialiser
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            msg_r <= M_COURSE;
            idx_r <= 5'd0;
            sum_r <= 8'h00;
            tail_r <= 2'd0;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
            sent_pulse <= 1'b0;
        end else begin
            sent_pulse <= 1'b0;
            if (tx_valid && tx_ready)
                tx_valid <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (launch) begin
                        msg_r <= pick;
                        tx_data <= 8'h24;                     // R12
                        tx_valid <= 1'b1;
                        idx_r <= 5'd0;
                        sum_r <= 8'h00;
                        state_r <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (!tx_valid || tx_ready) begin
                        if (idx_r < body_len) begin
                            tx_data <= body[idx_r[3:0]];
                            tx_valid <= 1'b1;
                            sum_r <= sum_r ^ body[idx_r[3:0]]; // R13
                            idx_r <= idx_r + 5'd1;
                        end else begin
                            tx_data <= 8'h2A;
                            tx_valid <= 1'b1;
                            tail_r <= 2'd0;
                            state_r <= S_TAIL;
                        end
                    end
                end
                S_TAIL: begin
                    if (!tx_valid || tx_ready) begin
                        tx_valid <= 1'b1;
                        tail_r <= tail_r + 2'd1;
                        case (tail_r)
                            2'd0: tx_data <= hex_char(sum_r[7:4]); // R13
                            2'd1: tx_data <= hex_char(sum_r[3:0]);
                            2'd2: tx_data <= 8'h0D;           // R12
                            default: begin
                                tx_data <= 8'h0A;
                                sent_pulse <= 1'b1;
                                state_r <= S_IDLE;            // R14
                            end
                        endcase
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // status_sentence_tx
`default_nettype wire
